// ===== rtl/tapirb_top.sv
// How it works
// - Select-IR-Scan: TMS low enters Capture-IR, TMS high enters Test-Logic-Reset.
// - Capture-IR loads 0001 into the instruction shift stage.
// - Capture-IR: TMS high goes Exit1-IR, low goes Shift-IR.
// - Shift-IR puts the instruction stage between TDI and TDO, one bit per edge.
// - Shift-IR: TMS high goes Exit1-IR, low stays.
// - Exit1-IR: TMS high goes Update-IR, low goes Pause-IR.
// - Pause-IR holds shifting while TMS low; TMS high goes Exit2-IR.
// - Exit2-IR: TMS high goes Update-IR, low returns to Shift-IR.
// - During IR states data registers stay put; the current instruction changes only in Update-IR.
// - Update-IR moves the shifted code to the instruction on falling TCK.
// - Boundary chain: one cell per pin, direction cells, reserved cell, fixed order.
// - A direction cell holding one floats or inputs its pins.
// - Four direction cells: data+parity, address, bus cycle, misc outputs.
// - Reset at power-up; five TMS-high clocks also reach Test-Logic-Reset.
// - State changes only on rising TCK or reset, steered by TMS.
// - Test-Logic-Reset loads the identification instruction.
// - Bypass code is all ones and selects a one-bit register.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tapirb_top
#(
   parameter logic [tapirb_pkg::ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary value
)
(
   // system clock and reset
   input  wire logic                          SYS_CLK,
   input  wire logic                          RESET,
   // register bus
   input  wire logic                          HSEL,
   input  wire logic [31:0]                   HADDR,
   input  wire logic [1:0]                    HTRANS,
   input  wire logic                          HWRITE,
   input  wire logic [2:0]                    HSIZE,
   input  wire logic [31:0]                   HWDATA,
   input  wire logic                          HREADY,
   output logic [31:0]                        HRDATA,
   output logic                               HREADYOUT,
   output logic                               HRESP,
   // test port
   input  wire logic                          TCK,
   input  wire logic                          TMS,
   input  wire logic                          TDI,
   output logic                               TDO,
   output logic                               TDO_OE,
   // pads
   input  wire logic [tapirb_pkg::BSR_LEN-1:0] PIN_IN,
   output logic [tapirb_pkg::BSR_LEN-1:0]      PIN_OUT,
   output logic [3:0]                          GROUP_OE,
   output logic                                EXTEST_ACTIVE
);
   import tapirb_pkg::*;

   // link domain
   logic                  rst_meta_ff;
   logic                  rst_tck_ff;
   tapirb_state_type      state_ff;
   tapirb_state_type      nxt_state;
   logic [IR_W-1:0]       ir_sr_ff;
   logic [IR_W-1:0]       ir_ff;
   logic                  ir_tog_ff;
   logic                  ir_by_upd_ff;
   logic                  bypass_ff;
   logic [ID_W-1:0]       id_sr_ff;
   logic                  ten_meta_ff;
   logic                  ten_tck_ff;
   logic                  tdo_ff;
   logic                  tdo_oe_ff;
   logic                  extest_ff;
   logic                  sel_bsr;
   logic                  bsr_so;
   logic                  dr_so;
   // system domain
   logic                  ctrl_ten_ff;
   logic                  tog_meta_ff;
   logic                  tog_sync_ff;
   logic                  tog_seen_ff;
   logic [IR_W-1:0]       inst_ff;
   logic [CNT_W-1:0]      upd_cnt_ff;
   logic                  wr_ph_ff;
   logic [AW-1:0]         wr_addr_ff;
   logic [31:0]           rdata_ff;
   logic                  ready_ff;
   logic                  resp_ff;
   logic                  acc;

   ////////////////////////////////////////////////////////////////////////
   // link-side reset: asserts at once, releases on a link edge
   always_ff @(posedge TCK or posedge RESET)
   begin
      if (RESET)
      begin
         rst_meta_ff <= 1'b1;
         rst_tck_ff  <= 1'b1;
      end
      else
      begin
         rst_meta_ff <= 1'b0;
         rst_tck_ff  <= rst_meta_ff;
      end
   end

   // software enable of test outputs crosses as a level
   always_ff @(posedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
      begin
         ten_meta_ff <= 1'b0;
         ten_tck_ff  <= 1'b0;
      end
      else
      begin
         ten_meta_ff <= ctrl_ten_ff;
         ten_tck_ff  <= ten_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // controller next state; five TMS-high edges reach TLR from anywhere
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         TLR:      nxt_state = TMS ? TLR      : RTI;
         RTI:      nxt_state = TMS ? SEL_DR   : RTI;
         SEL_DR:   nxt_state = TMS ? SEL_IR   : CAP_DR;
         CAP_DR:   nxt_state = TMS ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: nxt_state = TMS ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: nxt_state = TMS ? UPD_DR   : PAUSE_DR;
         PAUSE_DR: nxt_state = TMS ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: nxt_state = TMS ? UPD_DR   : SHIFT_DR;
         UPD_DR:   nxt_state = TMS ? SEL_DR   : RTI;
         SEL_IR:   nxt_state = TMS ? TLR      : CAP_IR;
         CAP_IR:   nxt_state = TMS ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: nxt_state = TMS ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: nxt_state = TMS ? UPD_IR   : PAUSE_IR;
         PAUSE_IR: nxt_state = TMS ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: nxt_state = TMS ? UPD_IR   : SHIFT_IR;
         UPD_IR:   nxt_state = TMS ? SEL_DR   : RTI;
         default:  nxt_state = TLR;
      endcase
   end

   // state moves only on rising TCK or reset
   always_ff @(posedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
         state_ff <= TLR;
      else
         state_ff <= nxt_state;
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction shift stage, bit 0 faces TDO
   always_ff @(posedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
         ir_sr_ff <= IR_CAPTURE;
      else if (state_ff == CAP_IR)
         ir_sr_ff <= IR_CAPTURE;
      else if (state_ff == SHIFT_IR)
         ir_sr_ff <= {TDI, ir_sr_ff[IR_W-1:1]};
   end

   // current instruction changes only on the falling edge in UPD_IR or TLR
   always_ff @(negedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
      begin
         ir_ff        <= IR_IDCODE;
         ir_tog_ff    <= 1'b0;
         ir_by_upd_ff <= 1'b0;
      end
      else if (state_ff == TLR)
      begin
         ir_ff <= IR_IDCODE;
         // only a real change is handed over, so the system mirror follows without counting it
         if (ir_ff != IR_IDCODE)
         begin
            ir_tog_ff    <= ~ir_tog_ff;
            ir_by_upd_ff <= 1'b0;
         end
      end
      else if (state_ff == UPD_IR)
      begin
         ir_ff        <= ir_sr_ff;
         ir_tog_ff    <= ~ir_tog_ff;
         ir_by_upd_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data registers only move in the DR states, so they hold across IR scans
   assign sel_bsr = (ir_ff == IR_EXTEST) || (ir_ff == IR_SAMPLE);

   // one-bit bypass; unknown codes fall back to it as well
   always_ff @(posedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
         bypass_ff <= 1'b0;
      else if (state_ff == CAP_DR)
         bypass_ff <= 1'b0;
      else if (state_ff == SHIFT_DR)
         bypass_ff <= TDI;
   end

   // identification register, read-only value shifted out LSB first
   always_ff @(posedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
         id_sr_ff <= '0;
      else if (state_ff == CAP_DR && ir_ff == IR_IDCODE)
         id_sr_ff <= ID_CODE;
      else if (state_ff == SHIFT_DR && ir_ff == IR_IDCODE)
         id_sr_ff <= {TDI, id_sr_ff[ID_W-1:1]};
   end

   // boundary chain with its latched parallel side
   tapirb_bsr #(
      .LEN (BSR_LEN)
   ) u_bsr (
      .tck        (TCK),
      .rst        (rst_tck_ff),
      .capture_en (state_ff == CAP_DR && sel_bsr),
      .shift_en   (state_ff == SHIFT_DR && sel_bsr),
      .update_en  (state_ff == UPD_DR && sel_bsr),
      .tdi        (TDI),
      .pin_in     (PIN_IN),
      .so         (bsr_so),
      .par_out    (PIN_OUT),
      .grp_oe     (GROUP_OE)
   );

   always_comb
   begin
      if (sel_bsr)
         dr_so = bsr_so;
      else if (ir_ff == IR_IDCODE)
         dr_so = id_sr_ff[0];
      else
         dr_so = bypass_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // serial output changes on falling TCK so the tester samples it on the rising one
   always_ff @(negedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
      begin
         tdo_ff    <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end
      else
      begin
         tdo_ff    <= (state_ff == SHIFT_IR) ? ir_sr_ff[0] : dr_so;
         tdo_oe_ff <= (state_ff == SHIFT_IR) || (state_ff == SHIFT_DR);
      end
   end

   assign TDO    = tdo_ff;
   assign TDO_OE = tdo_oe_ff;

   // EXTEST_ACTIVE is set only for the drive instruction with software consent; PIN_OUT and GROUP_OE take any EXTEST or SAMPLE update regardless
   always_ff @(posedge TCK or posedge rst_tck_ff)
   begin
      if (rst_tck_ff)
         extest_ff <= 1'b0;
      else
         extest_ff <= (ir_ff == IR_EXTEST) && ten_tck_ff && (state_ff != TLR);
   end

   assign EXTEST_ACTIVE = extest_ff;

   ////////////////////////////////////////////////////////////////////////
   // instruction updates cross as a toggle; the word is stable until the next
   // update, which cannot come sooner than several link clocks later
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         tog_meta_ff <= 1'b0;
         tog_sync_ff <= 1'b0;
         tog_seen_ff <= 1'b0;
      end
      else
      begin
         tog_meta_ff <= ir_tog_ff;
         tog_sync_ff <= tog_meta_ff;
         tog_seen_ff <= tog_sync_ff;
      end
   end

   // mirror of the current instruction and a count of updates
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         inst_ff    <= IR_IDCODE;
         upd_cnt_ff <= '0;
      end
      else if (tog_sync_ff != tog_seen_ff)
      begin
         inst_ff    <= ir_ff;
         if (ir_by_upd_ff)
            upd_cnt_ff <= upd_cnt_ff + CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register bus: zero wait states, every answer OKAY
   assign acc = HSEL && HREADY && (HTRANS == HTRANS_NSEQ);

   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         wr_ph_ff   <= 1'b0;
         wr_addr_ff <= '0;
         ready_ff   <= 1'b1;
         resp_ff    <= 1'b0;
      end
      else
      begin
         wr_ph_ff   <= acc && HWRITE;
         wr_addr_ff <= HADDR[AW-1:0];
         ready_ff   <= 1'b1;
         resp_ff    <= 1'b0;
      end
   end

   // control register written in the data phase
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
         ctrl_ten_ff <= 1'b0;
      else if (wr_ph_ff && wr_addr_ff == REG_CTRL)
         ctrl_ten_ff <= HWDATA[CTRL_TEN];
   end

   // read data fetched during the address phase, unmapped reads give zero
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
         rdata_ff <= '0;
      else if (acc && !HWRITE)
      begin
         rdata_ff <= '0;
         case (HADDR[AW-1:0])
            REG_CTRL: rdata_ff[CTRL_TEN] <= ctrl_ten_ff;
            REG_STATUS:
            begin
               rdata_ff[ST_IR_LSB +: IR_W]   <= inst_ff;
               // status flags test mode only when the EXTEST mirror and the software enable agree
               rdata_ff[ST_STATE_LSB]        <= (inst_ff == IR_EXTEST) && ctrl_ten_ff;
               rdata_ff[ST_CNT_LSB +: CNT_W] <= upd_cnt_ff;
            end
            default: rdata_ff <= '0;
         endcase
      end
   end

   assign HRDATA    = rdata_ff;
   assign HREADYOUT = ready_ff;
   assign HRESP     = resp_ff;

endmodule : tapirb_top
`default_nettype wire

// ===== rtl/tapirb_pkg.sv
package tapirb_pkg;

   ////////////////////////////////////////////////////////////////////////
   // instruction register
   localparam int             IR_W       = 4;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_IDCODE  = 4'h2;
   localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
   localparam logic [IR_W-1:0] IR_RUNBIST = 4'h8;
   localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h5;

   ////////////////////////////////////////////////////////////////////////
   // boundary chain, index 0 sits next to the serial input
   localparam int BSR_LEN      = 104;
   localparam int CELL_DATA    = 0;
   localparam int CELL_ADDR    = 1;
   localparam int CELL_BUS     = 2;
   localparam int CELL_MISC    = 3;
   localparam int ID_W         = 32;
   localparam int TLR_TMS_ONES = 5;

   ////////////////////////////////////////////////////////////////////////
   // register bus map
   localparam int              AW          = 8;
   localparam logic [AW-1:0]   REG_CTRL    = 8'h00;
   localparam logic [AW-1:0]   REG_STATUS  = 8'h04;
   localparam logic [1:0]      HTRANS_NSEQ = 2'h2;
   localparam int              CTRL_TEN    = 0;
   localparam int              ST_IR_LSB   = 0;
   localparam int              ST_STATE_LSB = 4;
   localparam int              ST_CNT_LSB  = 8;
   localparam int              CNT_W       = 8;

   ////////////////////////////////////////////////////////////////////////
   // controller states
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } tapirb_state_type;

endpackage : tapirb_pkg

// ===== rtl/tapirb_bsr.sv
`timescale 1ns/1ps
`default_nettype none
module tapirb_bsr
   import tapirb_pkg::*;
#(
   parameter int LEN = tapirb_pkg::BSR_LEN
)
(
   // link clock and reset
   input  wire logic           tck,
   input  wire logic           rst,
   // controller strobes
   input  wire logic           capture_en,
   input  wire logic           shift_en,
   input  wire logic           update_en,
   input  wire logic           tdi,
   // pads
   input  wire logic [LEN-1:0] pin_in,
   output logic                so,
   output logic [LEN-1:0]      par_out,
   output logic [3:0]          grp_oe
);

   logic [LEN-1:0] pin_meta_ff;
   logic [LEN-1:0] pin_sync_ff;
   logic [LEN-1:0] sr_ff;

   ////////////////////////////////////////////////////////////////////////
   // pad levels are asynchronous to the link clock
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
      begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end
      else
      begin
         pin_meta_ff <= pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // cell chain: capture pads, shift from index 0 toward the last cell
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         sr_ff <= '0;
      else if (capture_en)
         sr_ff <= pin_sync_ff;
      else if (shift_en)
         sr_ff <= {sr_ff[LEN-2:0], tdi};
   end

   assign so = sr_ff[LEN-1];

   // latched parallel side, direction cells reset to 1 so pads float
   always_ff @(negedge tck or posedge rst)
   begin
      if (rst)
      begin
         par_out <= '0;
         par_out[CELL_DATA] <= 1'b1;
         par_out[CELL_ADDR] <= 1'b1;
         par_out[CELL_BUS]  <= 1'b1;
         par_out[CELL_MISC] <= 1'b1;
         grp_oe  <= '0;
      end
      else if (update_en)
      begin
         par_out <= sr_ff;
         // a one in a direction cell floats its group, so enable is its inverse
         grp_oe  <= ~{sr_ff[CELL_MISC], sr_ff[CELL_BUS],
                      sr_ff[CELL_ADDR], sr_ff[CELL_DATA]};
      end
   end

endmodule : tapirb_bsr
`default_nettype wire

// ===== sim/tapirb_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module tapirb_top_props
   import tapirb_pkg::*;
(
   // register bus
   input wire logic               SYS_CLK,
   input wire logic               RESET,
   input wire logic               HSEL,
   input wire logic [1:0]         HTRANS,
   input wire logic               HWRITE,
   input wire logic               HREADY,
   input wire logic [31:0]        HRDATA,
   input wire logic               HREADYOUT,
   input wire logic               HRESP,
   // test port and pads
   input wire logic               TCK,
   input wire logic               TMS,
   input wire logic               TDO_OE,
   input wire logic [BSR_LEN-1:0] PIN_OUT,
   input wire logic [3:0]         GROUP_OE,
   input wire logic               EXTEST_ACTIVE
);
   ////////////////////////////////////////////////////////////////////////
   // bus: zero wait states, read data moves only after an accepted read
   property p_okay;
      @(posedge SYS_CLK) disable iff (RESET) HREADYOUT && !HRESP;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
   property p_rd_hold;
      @(posedge SYS_CLK) disable iff (RESET)
         $changed(HRDATA) |-> $past(HSEL && HREADY && HTRANS == 2'h2 && !HWRITE);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
   ////////////////////////////////////////////////////////////////////////
   // link: shift window follows the tms walk
   property p_oe_exit;
      @(posedge TCK) disable iff (RESET) TMS |=> !TDO_OE;
   endproperty
   a_oe_exit: assert property (p_oe_exit) else $error("still shifting after tms high");
   property p_oe_hold;
      @(posedge TCK) disable iff (RESET) TDO_OE && !TMS |=> TDO_OE;
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("shift left with tms low");
   property p_oe_enter;
      @(posedge TCK) disable iff (RESET) $rose(TDO_OE) |-> !$past(TMS);
   endproperty
   a_oe_enter: assert property (p_oe_enter) else $error("shift entered with tms high");
   property p_tlr;
      @(posedge TCK) disable iff (RESET) TMS [*6] |=> !EXTEST_ACTIVE;
   endproperty
   a_tlr: assert property (p_tlr) else $error("tms high run left test mode on");
   ////////////////////////////////////////////////////////////////////////
   // pads: direction cells steer the group enables, outputs move only on update
   property p_dir;
      @(posedge TCK) disable iff (RESET) GROUP_OE == ~PIN_OUT[3:0];
   endproperty
   a_dir: assert property (p_dir) else $error("group enable differs from its cell");
   // the first link edge has no history for $past, so the pad check waits one edge
   logic tck_run_ff;
   always_ff @(posedge TCK or posedge RESET)
   begin
      if (RESET)
         tck_run_ff <= 1'b0;
      else
         tck_run_ff <= 1'b1;
   end
   property p_pin_hold;
      @(posedge TCK) disable iff (RESET) tck_run_ff && $changed({PIN_OUT, GROUP_OE}) |-> $past(TMS);
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pad outputs moved outside update");
endmodule : tapirb_top_props

bind tapirb_top tapirb_top_props u_props (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .TCK(TCK), .TMS(TMS), .TDO_OE(TDO_OE), .PIN_OUT(PIN_OUT), .GROUP_OE(GROUP_OE),
   .EXTEST_ACTIVE(EXTEST_ACTIVE));
`default_nettype wire

// ===== sim/tapirb_tester.sv
`timescale 1ns/1ps
`default_nettype none
module tapirb_tester
(
   // tester drives the link
   output var logic TCK,
   output var logic TMS,
   output var logic TDI,
   // device serial output
   input wire logic TDO
);
   ////////////////////////////////////////////////////////////////////////
   // clock only runs inside steps, so it stands still between frames
   initial
   begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b1;
   end

   // one link period of 32 ns, tdo taken at the rising edge
   task step(input logic tms, input logic tdi, output logic tdo);
      TMS = tms;
      TDI = tdi;
      #16 TCK = 1'b1;
      tdo = TDO;
      #16 TCK = 1'b0;
   endtask : step

   // tms walk, lsb first; five ones reach reset from anywhere
   task go(input int n, input logic [15:0] t);
      logic d;
      for (int i = 0; i < n; i++)
         step(t[i], 1'b1, d);
   endtask : go

   // full scan from idle back to idle, bit k of din shifted at step k
   task scan(input logic ir, input int n, input logic [103:0] din, output logic [103:0] dout);
      logic d;
      go(ir ? 4 : 3, ir ? 16'h3 : 16'h1);
      dout = '0;
      for (int k = 0; k < n; k++)
      begin
         step(k == n - 1, din[k], d);
         dout[k] = d;
      end
      go(2, 16'h1);
   endtask : scan
endmodule : tapirb_tester
`default_nettype wire

// ===== sim/tapirb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tapirb_top_tb;
   import tapirb_pkg::*;
   localparam logic [31:0]  ID  = 32'h5A5A_0F0F; // arbitrary value
   localparam logic [103:0] PV  = {13{8'h96}};
   localparam logic [103:0] PIN = {13{8'h3C}};
   logic SYS_CLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP, TCK, TMS, TDI, TDO, TDO_OE, EXTEST_ACTIVE;
   logic [31:0]  HADDR, HWDATA, HRDATA, r;
   logic [1:0]   HTRANS;
   logic [2:0]   HSIZE;
   logic [103:0] PIN_OUT, v, din, ex;
   logic [3:0]   GROUP_OE;
   int           n_errors = 0;
   int           n_tests = 0;

   tapirb_top #(.ID_CODE(ID)) u_tapirb_top (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TCK(TCK), .TMS(TMS), .TDI(TDI),
      .TDO(TDO), .TDO_OE(TDO_OE), .PIN_IN(PIN), .PIN_OUT(PIN_OUT), .GROUP_OE(GROUP_OE),
      .EXTEST_ACTIVE(EXTEST_ACTIVE));
   tapirb_tester u_tapirb_tester (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));

   ////////////////////////////////////////////////////////////////////////
   // 40 MHz system clock
   initial SYS_CLK = 1'b0;
   always #12.5 SYS_CLK = ~SYS_CLK;

   task chk(input logic [103:0] g, input logic [103:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // single word transfer; waits on hready, no assumed latency
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge SYS_CLK);
      HSEL <= 1'b1;
      HADDR <= {24'h0, a};
      HTRANS <= HTRANS_NSEQ;
      HWRITE <= wr;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : ahb

   // status mirror lags the link by a few system clocks, so let it settle
   task st(input logic [3:0] ir, input logic [7:0] cnt, input logic ext);
      repeat (8) @(posedge SYS_CLK);
      ahb(1'b0, REG_STATUS, 32'h0, r);
      chk({r[15:8], r[4:0]}, {cnt, ext, ir});
   endtask : st

   task close_out;
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // watchdog: the whole walk needs well under this
   initial
   begin
      #400000;
      n_errors++;
      close_out();
   end

   initial
   begin
      {RESET, HSEL, HWRITE, HTRANS, HSIZE, HADDR, HWDATA} = {1'b1, 4'h0, 3'h2, 64'h0};
      repeat (6) @(posedge SYS_CLK);
      RESET <= 1'b0;
      u_tapirb_tester.go(6, 16'h1F);
      ahb(1'b0, REG_CTRL, 32'h0, r);
      chk(r, 0);
      st(IR_IDCODE, 0, 0);
      u_tapirb_tester.scan(0, 32, 0, v);
      chk(v[31:0], ID);
      u_tapirb_tester.scan(1, 4, IR_BYPASS, v);
      chk(v[3:0], IR_CAPTURE);
      st(IR_BYPASS, 1, 0);
      u_tapirb_tester.scan(0, 3, 104'h5, v);
      chk(v[2:0], 3'b010);
      // capture straight to exit1 and update loads the capture constant
      u_tapirb_tester.go(6, 16'h1B);
      st(IR_CAPTURE, 2, 0);
      // split shift with a pause in the middle
      u_tapirb_tester.go(4, 16'h3);
      u_tapirb_tester.step(0, 1, v[0]);
      u_tapirb_tester.step(1, 0, v[0]);
      u_tapirb_tester.go(2, 16'h0);
      st(IR_CAPTURE, 2, 0);
      u_tapirb_tester.go(2, 16'h1);
      u_tapirb_tester.step(0, 1, v[0]);
      u_tapirb_tester.step(1, 0, v[0]);
      u_tapirb_tester.go(2, 16'h1);
      st(IR_SAMPLE, 3, 0);
      u_tapirb_tester.go(4, 16'h7);
      st(IR_IDCODE, 3, 0);
      // boundary chain under test mode
      ahb(1'b1, REG_CTRL, 32'h1, r);
      u_tapirb_tester.scan(1, 4, IR_EXTEST, v);
      for (int k = 0; k < 104; k++)
      begin
         din[k] = PV[103 - k];
         ex[k] = PIN[103 - k];
      end
      u_tapirb_tester.scan(0, 104, din, v);
      chk(v, ex);
      chk(PIN_OUT, PV);
      chk(GROUP_OE, 4'(~PV[3:0]));
      chk(EXTEST_ACTIVE, 1);
      st(IR_EXTEST, 4, 1);
      ahb(1'b1, REG_CTRL, 32'h0, r);
      repeat (8) @(posedge SYS_CLK);
      // enable crosses two link flops, then the output register takes a third edge
      u_tapirb_tester.go(3, 16'h0);
      chk(EXTEST_ACTIVE, 0);
      // unmapped place and read-only status
      ahb(1'b1, 8'h10, 32'hFFFF_FFFF, r);
      ahb(1'b0, 8'h10, 32'h0, r);
      chk(r, 0);
      ahb(1'b1, REG_STATUS, 32'hFFFF_FFFF, r);
      st(IR_EXTEST, 4, 0);
      // test mode live again, then six tms-high edges must drop it
      ahb(1'b1, REG_CTRL, 32'h1, r);
      u_tapirb_tester.go(7, 16'h3F);
      chk(EXTEST_ACTIVE, 0);
      st(IR_IDCODE, 4, 0);
      close_out();
   end
endmodule : tapirb_top_tb
`default_nettype wire
